// ---- gafo_board.sv ----
// Purpose: board model at the pads of the pin function block
// Assumes: the board drives every pad that the block releases
// Notes: a released pad shows the board level, never the old drive
module gafo_board (
  // pad side of the block
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // board drivers
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // gafo_board

// ---- gafo_consts.svh ----
// Purpose: constants of the pin function block
// Assumes: register index times four gives the byte address
// Notes: values of the pin and antenna registers
`ifndef GAFO_CONSTS_SVH
`define GAFO_CONSTS_SVH
`define GAFO_IDX_FUNC_SEL    8'h4F
`define GAFO_IDX_OUT_LEVEL   8'h50
`define GAFO_IDX_DIRECTION   8'h51
`define GAFO_IDX_IN_LEVEL    8'h52
`define GAFO_IDX_ANT_CTRL    8'h5F
`define GAFO_RST_FUNC_SEL    8'h00
`define GAFO_RST_OUT_LEVEL   8'h00
`define GAFO_RST_DIRECTION   8'hFF
`define GAFO_RST_ANT_CTRL    8'h00
`define GAFO_MASK_FUNC_SEL   8'hC0
`define GAFO_MASK_GP_BITS    8'hFD
`define GAFO_MASK_ANT_CTRL   8'h01
`define GAFO_BIT_PIN7_SEL    7
`define GAFO_BIT_PIN65_SEL   6
`define GAFO_BIT_TWO_PIN     0
`define GAFO_PIN_IRQ         7
`define GAFO_PIN_RSVD6       6
`define GAFO_PIN_SYNC        5
`define GAFO_PIN_ANT_DIR     1
`define GAFO_PIN_ANT_IN      0
`define GAFO_RESP_OKAY       2'h0
`define GAFO_RESP_SLVERR     2'h2
`endif

// ---- gafo_pin_mux.sv ----
// Purpose: pin routing and input synchronisers
// Assumes: alternate sources come from logic on aclk
// Notes: drive is registered, one cycle behind the registers
`include "gafo_consts.svh"
module gafo_pin_mux (
  // clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // configuration
  input  wire logic [7:0]               func_sel,
  input  wire logic [7:0]               out_level,
  input  wire logic [7:0]               direction,
  input  wire logic                     two_pin_mode,
  // alternate sources
  input  wire logic                     host_interrupt_request,
  input  wire logic                     sync_pulse_output,
  input  wire logic                     antenna_dir,
  // pins
  input  wire logic [7:0]               pin_in,
  output gafo_pkg::gafo_pin_drive_t     pin_drive,
  output logic      [7:0]               pin_sync,
  output logic                          antenna_control_input
);
  import gafo_pkg::*;

  gafo_pin_drive_t drive_r, drive_nxt;
  logic [7:0]      meta_r, sync_r;

  always_comb begin
    // data bit reaches pin_out whatever the direction; enable alone decides if the pad is driven
    drive_nxt.level  = out_level & `GAFO_MASK_GP_BITS;
    drive_nxt.enable = ~direction & `GAFO_MASK_GP_BITS;
    if (func_sel[`GAFO_BIT_PIN7_SEL]) begin
      drive_nxt.level[`GAFO_PIN_IRQ]  = host_interrupt_request;
      drive_nxt.enable[`GAFO_PIN_IRQ] = 1'b1;
    end
    if (func_sel[`GAFO_BIT_PIN65_SEL]) begin
      drive_nxt.level[`GAFO_PIN_SYNC]   = sync_pulse_output;
      drive_nxt.enable[`GAFO_PIN_SYNC]  = 1'b1;
      drive_nxt.level[`GAFO_PIN_RSVD6]  = 1'b0;
      drive_nxt.enable[`GAFO_PIN_RSVD6] = 1'b0;
    end
    if (two_pin_mode) begin
      drive_nxt.level[`GAFO_PIN_ANT_IN]  = 1'b0;
      drive_nxt.enable[`GAFO_PIN_ANT_IN] = 1'b0;
    end
    // pin 1 ignores every general purpose bit
    drive_nxt.level[`GAFO_PIN_ANT_DIR]  = antenna_dir & ~two_pin_mode;
    drive_nxt.enable[`GAFO_PIN_ANT_DIR] = ~two_pin_mode;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_r <= '0;
      meta_r  <= 8'h00;
      sync_r  <= 8'h00;
    end else begin
      drive_r <= drive_nxt;
      meta_r  <= pin_in;
      sync_r  <= meta_r;
    end
  end

  assign pin_drive             = drive_r;
  assign pin_sync              = sync_r;
  // only meaningful in two-pin mode; held low otherwise
  assign antenna_control_input = sync_r[`GAFO_PIN_ANT_IN] & two_pin_mode;
endmodule // gafo_pin_mux

// ---- gafo_pkg.sv ----
// Purpose: shared types of the pin function block
// Assumes: eight pins
// Notes: pin drive travels as one struct
package gafo_pkg;
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] enable;
  } gafo_pin_drive_t;
endpackage

// ---- gafo_props.sv ----
// Purpose: port checker of the pin function block
// Assumes: one aclk domain, synchronous active-low reset
// Notes: bound into gafo_top, sees its ports only
`include "gafo_consts.svh"
module gafo_props (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // pins
  input wire logic        antenna_dir,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe,
  input wire logic        antenna_control_input
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_go;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_go;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_go |=> ##[0:1] s_axi_bvalid)
    else $error("write answer late");
  a_wr_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_wr_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_rd_answer: assert property (s_rd_go |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_rd_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  a_pin1_link: assert property (pin_oe[1] |->
    pin_out[1] == $past(antenna_dir)) else $error("pin 1 not link dir");
  a_ant_in_pins: assert property (
    antenna_control_input && $past(antenna_control_input) |->
    !pin_oe[0] && !pin_oe[1]) else $error("pins 0 or 1 driven");
endmodule // gafo_props
bind gafo_top gafo_props gafo_props_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .antenna_dir, .pin_out,
  .pin_oe, .antenna_control_input);

// ---- gafo_top.sv ----
// Purpose: pin function select and output level registers over AXI4-Lite
// Assumes: single aclk domain, 32-bit bus, one register per word
// Notes: byte address is four times the register index
`include "gafo_consts.svh"
module gafo_top (
  // clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // axi write address
  input  wire logic [31:0]              s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  // axi write data
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  // axi write response
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // axi read address
  input  wire logic [31:0]              s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  // axi read data
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // alternate function sources
  input  wire logic                     host_interrupt_request,
  input  wire logic                     sync_pulse_output,
  input  wire logic                     antenna_dir,
  // pins
  input  wire logic [7:0]               pin_in,
  output logic      [7:0]               pin_out,
  output logic      [7:0]               pin_oe,
  output logic                          antenna_control_input
);
  import gafo_pkg::*;

  function automatic logic [7:0] word_index(input logic [31:0] addr);
    word_index = addr[9:2];
  endfunction

  function automatic logic known_index(input logic [7:0] idx);
    known_index = (idx == `GAFO_IDX_FUNC_SEL) ||
                  (idx == `GAFO_IDX_OUT_LEVEL) ||
                  (idx == `GAFO_IDX_DIRECTION) ||
                  (idx == `GAFO_IDX_IN_LEVEL) ||
                  (idx == `GAFO_IDX_ANT_CTRL);
  endfunction

  // registers
  logic [7:0]  func_sel_r, func_sel_nxt;
  logic [7:0]  out_level_r, out_level_nxt;
  logic [7:0]  direction_r, direction_nxt;
  logic [7:0]  ant_ctrl_r, ant_ctrl_nxt;
  // write channel state
  logic        aw_got_r, aw_got_nxt;
  logic        w_got_r, w_got_nxt;
  logic [31:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic        wstrb0_r, wstrb0_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  // read channel state
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;

  gafo_pin_drive_t drive;
  logic [7:0]      pin_sync;
  logic [7:0]      widx;
  logic [7:0]      ridx;
  logic [7:0]      wbyte;
  logic            do_write;

  // address and data are each taken once; no new write until bresp leaves
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;

  always_comb begin
    aw_got_nxt    = aw_got_r;
    w_got_nxt     = w_got_r;
    awaddr_nxt    = awaddr_r;
    wdata_nxt     = wdata_r;
    wstrb0_nxt    = wstrb0_r;
    bvalid_nxt    = bvalid_r;
    bresp_nxt     = bresp_r;
    func_sel_nxt  = func_sel_r;
    out_level_nxt = out_level_r;
    direction_nxt = direction_r;
    ant_ctrl_nxt  = ant_ctrl_r;
    widx          = word_index(awaddr_r);
    wbyte         = wdata_r[7:0];
    do_write      = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt  = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
    end
    // both halves held: commit one cycle after the later one arrives
    if (aw_got_r && w_got_r) begin
      do_write   = wstrb0_r;
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      if (known_index(widx)) begin
        bresp_nxt = `GAFO_RESP_OKAY;
      end else begin
        bresp_nxt = `GAFO_RESP_SLVERR;
      end
    end
    if (do_write) begin
      case (widx)
        `GAFO_IDX_FUNC_SEL: begin
          func_sel_nxt = wbyte & `GAFO_MASK_FUNC_SEL;
        end
        `GAFO_IDX_OUT_LEVEL: begin
          out_level_nxt = wbyte & `GAFO_MASK_GP_BITS;
        end
        `GAFO_IDX_DIRECTION: begin
          // bit 1 stays set so pin 1 never looks like an output
          direction_nxt = wbyte | ~`GAFO_MASK_GP_BITS;
        end
        `GAFO_IDX_ANT_CTRL: begin
          ant_ctrl_nxt = wbyte & `GAFO_MASK_ANT_CTRL;
        end
        default: begin
          ant_ctrl_nxt = ant_ctrl_r;
        end
      endcase
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    ridx       = word_index(s_axi_araddr);
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `GAFO_RESP_OKAY;
      case (ridx)
        `GAFO_IDX_FUNC_SEL:  rdata_nxt = {24'h000000, func_sel_r};
        `GAFO_IDX_OUT_LEVEL: rdata_nxt = {24'h000000, out_level_r};
        `GAFO_IDX_DIRECTION: rdata_nxt = {24'h000000, direction_r};
        `GAFO_IDX_IN_LEVEL: begin
          rdata_nxt = {24'h000000, pin_sync & `GAFO_MASK_GP_BITS};
        end
        `GAFO_IDX_ANT_CTRL:  rdata_nxt = {24'h000000, ant_ctrl_r};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = `GAFO_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      func_sel_r  <= `GAFO_RST_FUNC_SEL;
      out_level_r <= `GAFO_RST_OUT_LEVEL;
      direction_r <= `GAFO_RST_DIRECTION;
      ant_ctrl_r  <= `GAFO_RST_ANT_CTRL;
      aw_got_r    <= 1'b0;
      w_got_r     <= 1'b0;
      awaddr_r    <= 32'h00000000;
      wdata_r     <= 32'h00000000;
      wstrb0_r    <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= `GAFO_RESP_OKAY;
      rvalid_r    <= 1'b0;
      rdata_r     <= 32'h00000000;
      rresp_r     <= `GAFO_RESP_OKAY;
    end else begin
      func_sel_r  <= func_sel_nxt;
      out_level_r <= out_level_nxt;
      direction_r <= direction_nxt;
      ant_ctrl_r  <= ant_ctrl_nxt;
      aw_got_r    <= aw_got_nxt;
      w_got_r     <= w_got_nxt;
      awaddr_r    <= awaddr_nxt;
      wdata_r     <= wdata_nxt;
      wstrb0_r    <= wstrb0_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      rvalid_r    <= rvalid_nxt;
      rdata_r     <= rdata_nxt;
      rresp_r     <= rresp_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  gafo_pin_mux u_pin_mux (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .func_sel               (func_sel_r),
    .out_level              (out_level_r),
    .direction              (direction_r),
    .two_pin_mode           (ant_ctrl_r[`GAFO_BIT_TWO_PIN]),
    .host_interrupt_request (host_interrupt_request),
    .sync_pulse_output      (sync_pulse_output),
    .antenna_dir            (antenna_dir),
    .pin_in                 (pin_in),
    .pin_drive              (drive),
    .pin_sync               (pin_sync),
    .antenna_control_input  (antenna_control_input)
  );

  assign pin_out = drive.level;
  assign pin_oe  = drive.enable;
endmodule // gafo_top

// ---- test_gpio_alt_function_output.sv ----
// Purpose: self-checking bench of the pin function block
// Assumes: drive lags registers one clock, inputs two clocks
// Notes: pin_out only compared where pin_oe is high
`include "gafo_consts.svh"
module test_gpio_alt_function_output;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] A_FS = {22'h0, `GAFO_IDX_FUNC_SEL, 2'b00};
  localparam logic [31:0] A_LV = {22'h0, `GAFO_IDX_OUT_LEVEL, 2'b00};
  localparam logic [31:0] A_DR = {22'h0, `GAFO_IDX_DIRECTION, 2'b00};
  localparam logic [31:0] A_IN = {22'h0, `GAFO_IDX_IN_LEVEL, 2'b00};
  localparam logic [31:0] A_AC = {22'h0, `GAFO_IDX_ANT_CTRL, 2'b00};
  localparam logic [1:0]  OK = `GAFO_RESP_OKAY;
  logic aclk = 0, aresetn = 0, irq = 0, syn = 0, adir = 0, aci, two;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0]  pin_in, pin_out, pin_oe, ext = 0, fs, lvl, dir, o, oe, pad;
  int n_fail = 0, checks_done = 0;
  always #10 aclk = ~aclk;
  gafo_top gafo_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .host_interrupt_request(irq), .sync_pulse_output(syn),
    .antenna_dir(adir), .pin_in, .pin_out, .pin_oe,
    .antenna_control_input(aci));
  gafo_board gafo_board_i (.pin_out, .pin_oe, .ext_level(ext), .pin_in);
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait: a bus that never answers ends the run
  // bready comes after a random stall so a held response is exercised
  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    int n, s;
    n = 0;
    s = $urandom % 5;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) break;
      if (n >= s) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) begin
      n_fail++;
      test_done;
    end else begin
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    end
  endtask
  task automatic rc(input string nm, input logic [31:0] a, e,
                    input logic [1:0] er);
    int n, s;
    n = 0;
    s = $urandom % 5;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (n < 50) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) break;
      if (n >= s) s_axi_rready <= 1'b1;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) begin
      n_fail++;
      test_done;
    end else begin
      chk(nm, e, rd);
      chk("rresp", {30'h0, er}, {30'h0, rsp});
    end
  endtask
  function automatic logic [15:0] exp_pins(input logic [7:0] f, l, d,
                                           input logic t, i, s, a);
    logic [7:0] e, v;
    e = ~d & `GAFO_MASK_GP_BITS;
    v = l & e;
    e[7] = e[7] | f[7];
    v[7] = f[7] ? i : v[7];
    e[6] = e[6] & ~f[6];
    e[5] = e[5] | f[6];
    v[5] = f[6] ? s : v[5];
    e[1] = ~t;
    v[1] = a & ~t;
    e[0] = e[0] & ~t;
    return {v & e, e};
  endfunction
  initial begin
    void'($urandom(62));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("oe after reset", 8'h02, pin_oe);
    rc("select", A_FS, 0, OK);
    rc("levels", A_LV, 0, OK);
    rc("direction", A_DR, 32'hFF, OK);
    wr(A_FS, 32'hFFFFFFFF, OK);
    rc("select", A_FS, 32'hC0, OK);
    $display("reset and reserved test done");
    for (int k = 0; k < 24; k++) begin
      fs = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
      dir = (k < 2) ? 8'h00 : 8'($urandom);
      two = (k == 1) ? 1'b1 : (k == 0) ? 1'b0 : 1'($urandom);
      lvl = (k < 2) ? 8'hFF : 8'($urandom);
      wr(A_FS, {24'h0, fs}, OK);
      wr(A_LV, {24'h0, lvl}, OK);
      wr(A_DR, {24'h0, dir}, OK);
      wr(A_AC, {31'h0, two}, OK);
      irq <= 1'($urandom);
      syn <= 1'($urandom);
      adir <= 1'($urandom);
      ext <= (k == 1) ? 8'h01 : 8'($urandom);
      repeat (3) @(posedge aclk);
      {o, oe} = exp_pins(fs, lvl, dir, two, irq, syn, adir);
      pad = o | (ext & ~oe);
      chk("pin_oe", oe, pin_oe);
      chk("pin_out", o, pin_out & pin_oe);
      chk("antenna in", two & pad[0], aci);
      rc("levels", A_LV, lvl & 8'hFD, OK);
      rc("select", A_FS, fs & 8'hC0, OK);
      rc("direction", A_DR, {24'h0, dir | 8'h02}, OK);
      rc("antenna ctrl", A_AC, {31'h0, two}, OK);
      rc("inputs", A_IN, {24'h0, pad & 8'hFD}, OK);
    end
    $display("pin routing test done");
    // a write with byte lane 0 off must leave the register alone
    s_axi_wstrb <= 4'h0;
    wr(A_LV, {24'h0, ~lvl}, OK);
    s_axi_wstrb <= 4'hF;
    rc("masked write", A_LV, {24'h0, lvl & 8'hFD}, OK);
    $display("strobe test done");
    wr(32'h0, 32'hFF, `GAFO_RESP_SLVERR);
    rc("unmapped", 32'h0, 0, `GAFO_RESP_SLVERR);
    $display("unmapped test done");
    test_done;
  end
endmodule // test_gpio_alt_function_output
